/* shared/mbs_defs.vh */
// Constants for the RTU slave buffer map block.
// Assumes inclusion by bare name from the design file.
`ifndef MBS_DEFS_VH
`define MBS_DEFS_VH

// ==========================================
// Buffer sizes
`define MBS_BUF_DEPTH 1024
`define MBS_REQ_DEPTH 256

// ==========================================
// Register word indexes
`define MBS_REG_CTRL 2'h0
`define MBS_REG_FBLEN 2'h1
`define MBS_REG_STATUS 2'h2

// ==========================================
// Fields and reset values
`define MBS_CTRL_TRIG_BIT 0
`define MBS_CTRL_LEN_BIT 1
`define MBS_CTRL_RESET 2'h2
`define MBS_FBLEN_RESET 11'h010
`define MBS_STAT_BUSY_BIT 24

// ==========================================
// Function codes and protocol values
`define MBS_FC_RD_COIL 8'h01
`define MBS_FC_RD_DISC 8'h02
`define MBS_FC_RD_HOLD 8'h03
`define MBS_FC_RD_INP 8'h04
`define MBS_FC_WR_COIL 8'h05
`define MBS_FC_WR_REG 8'h06
`define MBS_FC_WR_COILS 8'h0f
`define MBS_FC_WR_REGS 8'h10
`define MBS_COIL_ON 8'hff
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001
`define MBS_MIN_FRAME 9'h004

`endif

/* design/mbs_slave.v */
// RTU slave command interpreter serving a shared fieldbus byte buffer.
// Assumes character framing outside: one byte per rx_valid, rx_frame_end
// after the last byte of a frame; fieldbus bytes arrive as a plain stream.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mbs_defs.vh"

module mbs_slave (
    input wire clk,
    input wire rst,
    input wire [1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [3:0] slave_id_high_switch,
    input wire [3:0] slave_id_low_switch,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_frame_end,
    output reg tx_valid,
    output reg [7:0] tx_data,
    input wire tx_ready,
    input wire fb_in_valid,
    input wire [7:0] fb_in_data,
    input wire fb_in_last,
    output reg fb_out_valid,
    output reg [7:0] fb_out_data,
    output reg fb_out_last,
    input wire fb_out_ready
);

    localparam ST_IDLE = 4'b0001;
    localparam ST_EXEC = 4'b0010;
    localparam ST_RESP = 4'b0100;
    localparam ST_FBOUT = 4'b1000;

    function [15:0] crc_step;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] x;
        begin
            x = c ^ {8'h00, d};
            for (i = 0; i < 8; i = i + 1)
                x = x[0] ? ((x >> 1) ^ `MBS_CRC_POLY) : (x >> 1);
            crc_step = x;
        end
    endfunction

    // ==========================================
    // Storage
    // buffer depth
    reg [7:0] buf_in [0:`MBS_BUF_DEPTH-1];
    reg [7:0] buf_out [0:`MBS_BUF_DEPTH-1];
    reg [7:0] req_mem [0:`MBS_REQ_DEPTH-1];

    reg [3:0] state;
    reg [1:0] ctrl;
    reg [10:0] fb_out_len;
    reg bus_ack;
    reg [7:0] sw_s1, sw_s2, sw_s3, slave_id;
    reg [8:0] rx_cnt;
    reg [15:0] rx_crc;
    reg [7:0] req_cnt, crc_err_cnt;
    reg [7:0] wr_k;
    reg [8:0] r_idx;
    reg [15:0] tx_crc;
    reg pend_fb;
    reg [11:0] fo_idx;
    reg [7:0] fo_trig;
    reg [1:0] fbi_stage;
    reg [7:0] fbi_len;
    reg [10:0] fbi_idx;

    wire trig_en = ctrl[`MBS_CTRL_TRIG_BIT];
    wire len_en = ctrl[`MBS_CTRL_LEN_BIT];

    // ==========================================
    // Rotary selectors
    // high and low digit
    always @(posedge clk) begin
        if (rst) begin
            sw_s1 <= 8'h00;
            sw_s2 <= 8'h00;
            sw_s3 <= 8'h00;
            slave_id <= 8'h00;
        end else begin
            sw_s1 <= {slave_id_high_switch, slave_id_low_switch};
            sw_s2 <= sw_s1;
            sw_s3 <= sw_s2;
            // Only a settled selector position is taken
            if (sw_s2 == sw_s3)
                slave_id <= sw_s3;
        end
    end

    // ==========================================
    // Request decode
    wire [7:0] fc = req_mem[1];
    wire [15:0] q_addr = {req_mem[2], req_mem[3]};
    wire [15:0] q_cnt = {req_mem[4], req_mem[5]};
    wire is_bit = (fc == `MBS_FC_RD_COIL) || (fc == `MBS_FC_RD_DISC);
    wire is_reg = (fc == `MBS_FC_RD_HOLD) || (fc == `MBS_FC_RD_INP);
    wire is_wr = (fc == `MBS_FC_WR_COIL) || (fc == `MBS_FC_WR_REG) ||
                 (fc == `MBS_FC_WR_COILS) || (fc == `MBS_FC_WR_REGS);
    wire coil_wr = (fc == `MBS_FC_WR_COIL) || (fc == `MBS_FC_WR_COILS);
    wire [7:0] rd_nbytes = is_bit ? (q_cnt[10:3] + {7'h00, |q_cnt[2:0]})
                                  : {q_cnt[6:0], 1'b0};
    wire [9:0] bit_base = q_addr[12:3];
    wire [9:0] reg_base = {q_addr[8:0], 1'b0};
    wire [8:0] r_len = (is_bit || is_reg) ? (9'h003 + {1'b0, rd_nbytes}) : 9'h006;
    wire [7:0] n_wr = (fc == `MBS_FC_WR_COIL) ? 8'h01 :
                      (fc == `MBS_FC_WR_REG) ? 8'h02 : req_mem[6];

    wire frame_ok = (rx_crc == 16'h0000) && (rx_cnt >= `MBS_MIN_FRAME) &&
                    (req_mem[0] == slave_id) && (is_bit || is_reg || is_wr);

    // ==========================================
    // Write byte generation
    reg [9:0] w_dest;
    reg [7:0] w_data, w_mask;
    always @* begin
        // coil writes map on byte bounds
        w_dest = (coil_wr ? bit_base : reg_base) + {2'b00, wr_k};
        w_mask = 8'hff;
        // low byte first in buffer is high half
        w_data = (fc == `MBS_FC_WR_REG) ? req_mem[8'h04 + wr_k] : req_mem[8'h07 + wr_k];
        if (fc == `MBS_FC_WR_COIL) begin
            w_mask = 8'h01 << q_addr[2:0];
            w_data = (req_mem[4] == `MBS_COIL_ON) ? 8'hff : 8'h00;
        end else if (fc == `MBS_FC_WR_COILS && wr_k == n_wr - 8'h01 && q_cnt[2:0] != 3'h0) begin
            // Last partial byte keeps coils beyond the count
            w_mask = (8'h01 << q_cnt[2:0]) - 8'h01;
        end
    end
    wire w_go = (state == ST_EXEC) && is_wr && (wr_k < n_wr);

    // ==========================================
    // Fieldbus input parse
    // trigger then length then data
    wire fbi_is_trig = (fbi_stage == 2'h0) && trig_en;
    wire fbi_is_len = !fbi_is_trig && (fbi_stage != 2'h2) && len_en;
    wire fbi_wr = fb_in_valid && !fbi_is_trig && !fbi_is_len &&
                  (!len_en || fbi_idx < {3'h0, fbi_len}) && (fbi_idx < `MBS_BUF_DEPTH);

    always @(posedge clk) begin
        if (rst) begin
            fbi_stage <= 2'h0;
            fbi_len <= 8'h00;
            fbi_idx <= 11'h000;
        end else if (fb_in_valid) begin
            if (fb_in_last) begin
                fbi_stage <= 2'h0;
                fbi_idx <= 11'h000;
            end else begin
                fbi_stage <= fbi_is_trig ? 2'h1 : 2'h2;
                if (fbi_is_len)
                    fbi_len <= fb_in_data;
                if (!fbi_is_trig && !fbi_is_len)
                    fbi_idx <= fbi_idx + 11'h001;
            end
        end
    end

    // Serial writes win a shared cycle; the fieldbus byte is then dropped
    always @(posedge clk) begin
        if (w_go) begin
            buf_in[w_dest] <= (buf_in[w_dest] & ~w_mask) | (w_data & w_mask);
            buf_out[w_dest] <= (buf_out[w_dest] & ~w_mask) | (w_data & w_mask);
        end else if (fbi_wr) begin
            buf_in[fbi_idx[9:0]] <= fb_in_data;
        end
        if (state == ST_IDLE && rx_valid && !rx_cnt[8])
            req_mem[rx_cnt[7:0]] <= rx_data;
    end

    // ==========================================
    // Response and fieldbus output bytes
    reg [7:0] rb, fb;
    reg [9:0] rd_ix;
    reg [11:0] fo_pay;
    always @* begin
        rd_ix = (is_bit ? bit_base : reg_base) + r_idx[9:0] - 10'h003;
        if (r_idx == r_len)
            rb = tx_crc[7:0];
        else if (r_idx > r_len)
            rb = tx_crc[15:8];
        else if (!(is_bit || is_reg) || r_idx < 9'h002)
            rb = req_mem[r_idx[7:0]];
        else if (r_idx == 9'h002)
            rb = rd_nbytes;
        else if (fc == `MBS_FC_RD_HOLD)
            rb = buf_out[rd_ix];
        // input and bits from incoming buffer
        else
            rb = buf_in[rd_ix];
        fo_pay = fo_idx - {11'h000, trig_en} - {11'h000, len_en};
        if (trig_en && fo_idx == 12'h000)
            fb = fo_trig;
        else if (len_en && fo_idx == {11'h000, trig_en})
            fb = fb_out_len[7:0];
        else
            fb = buf_out[fo_pay[9:0]];
    end
    wire [11:0] fo_total = {1'b0, fb_out_len} + {11'h000, trig_en} + {11'h000, len_en};

    // ==========================================
    // Main sequencer
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            rx_cnt <= 9'h000;
            rx_crc <= `MBS_CRC_INIT;
            req_cnt <= 8'h00;
            crc_err_cnt <= 8'h00;
            wr_k <= 8'h00;
            r_idx <= 9'h000;
            tx_crc <= `MBS_CRC_INIT;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            pend_fb <= 1'b0;
            fo_idx <= 12'h000;
            fo_trig <= 8'h00;
            fb_out_valid <= 1'b0;
            fb_out_data <= 8'h00;
            fb_out_last <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Bytes arriving while busy are ignored
                    if (rx_frame_end) begin
                        rx_cnt <= 9'h000;
                        rx_crc <= `MBS_CRC_INIT;
                        wr_k <= 8'h00;
                        if (frame_ok) begin
                            state <= ST_EXEC;
                            req_cnt <= req_cnt + 8'h01;
                        end else if (rx_crc != 16'h0000) begin
                            crc_err_cnt <= crc_err_cnt + 8'h01;
                        end
                    end else if (rx_valid) begin
                        rx_crc <= crc_step(rx_crc, rx_data);
                        if (!rx_cnt[8])
                            rx_cnt <= rx_cnt + 9'h001;
                    end
                end
                ST_EXEC: begin
                    if (w_go) begin
                        wr_k <= wr_k + 8'h01;
                    end else begin
                        state <= ST_RESP;
                        r_idx <= 9'h000;
                        tx_crc <= `MBS_CRC_INIT;
                        pend_fb <= is_wr;
                    end
                end
                ST_RESP: begin
                    if (!tx_valid) begin
                        tx_valid <= 1'b1;
                        tx_data <= rb;
                        if (r_idx < r_len)
                            tx_crc <= crc_step(tx_crc, rb);
                    end else if (tx_ready) begin
                        tx_valid <= 1'b0;
                        r_idx <= r_idx + 9'h001;
                        if (r_idx == r_len + 9'h001) begin
                            state <= pend_fb ? ST_FBOUT : ST_IDLE;
                            fo_idx <= 12'h000;
                        end
                    end
                end
                ST_FBOUT: begin
                    if (!fb_out_valid) begin
                        fb_out_valid <= 1'b1;
                        fb_out_data <= fb;
                        fb_out_last <= (fo_idx == fo_total - 12'h001);
                    end else if (fb_out_ready) begin
                        fb_out_valid <= 1'b0;
                        fb_out_last <= 1'b0;
                        fo_idx <= fo_idx + 12'h001;
                        if (fb_out_last) begin
                            state <= ST_IDLE;
                            pend_fb <= 1'b0;
                            fo_trig <= fo_trig + 8'h01;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Register bus slave, one wait state per access
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

    always @(posedge clk) begin
        if (rst) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            ctrl <= `MBS_CTRL_RESET;
            fb_out_len <= `MBS_FBLEN_RESET;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
            if (avs_read && !bus_ack) begin
                case (avs_address)
                    `MBS_REG_CTRL: avs_readdata <= {30'h00000000, ctrl};
                    `MBS_REG_FBLEN: avs_readdata <= {21'h000000, fb_out_len};
                    `MBS_REG_STATUS: avs_readdata <= {7'h00, state != ST_IDLE,
                                                      crc_err_cnt, req_cnt, slave_id};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            // Change mid-frame would misparse; set while idle
            if (avs_write && bus_ack) begin
                if (avs_address == `MBS_REG_CTRL)
                    ctrl <= avs_writedata[1:0];
                if (avs_address == `MBS_REG_FBLEN)
                    fb_out_len <= avs_writedata[10:0];
            end
        end
    end

endmodule // mbs_slave

/* dv/mbs_slave_properties.sv */
// Checker for the RTU slave: bus handshake, reply framing, fieldbus output.
// Assumes a bind onto mbs_slave; switches stay still after reset.
`timescale 1ns/1ps
module mbs_props (
    input wire clk,
    input wire rst,
    input wire [1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [3:0] slave_id_high_switch,
    input wire [3:0] slave_id_low_switch,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_frame_end,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_ready,
    input wire fb_out_valid,
    input wire fb_out_last,
    input wire fb_out_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ========
    // Frame tracking, byte counts cleared at each frame end
    reg [7:0] fc;
    reg [9:0] rx_n;
    reg [9:0] tx_n;
    always @(posedge clk) begin
        if (rst || rx_frame_end) begin
            rx_n <= 10'h000;
            tx_n <= 10'h000;
        end else begin
            if (rx_valid)
                rx_n <= rx_n + 10'h001;
            if (rx_valid && rx_n == 10'h001)
                fc <= rx_data;
            if (tx_valid && tx_ready)
                tx_n <= tx_n + 10'h001;
        end
    end
    wait_one_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait not one cycle");
    unmapped_zero_a: assert property (avs_read && avs_address == 2'h3 && !avs_waitrequest
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");
    tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("no gap");
    fbo_hold_a: assert property (fb_out_valid && !fb_out_ready |=> fb_out_valid
        && $stable(fb_out_last)) else $error("fieldbus byte dropped");
    fbo_cause_a: assert property ($rose(fb_out_valid) |->
        fc inside {8'h05, 8'h06, 8'h0f, 8'h10}) else $error("output without write");
    reply_id_a: assert property (tx_valid && tx_n == 10'h000 |->
        tx_data == {slave_id_high_switch, slave_id_low_switch}) else $error("reply id");
    fbo_last_a: assert property (fb_out_last |-> fb_out_valid)
        else $error("last without valid");
endmodule // mbs_props
bind mbs_slave mbs_props i_mbs_props (.*);

/* dv/mbs_master.sv */
// Serial master model: sends request frames with CRC, drains reply bytes.
// Assumes the bench calls send and empties got; slow stalls the replies.
`timescale 1ns/1ps
module mbs_master (
    input wire clk,
    input wire slow,
    input wire tx_valid,
    input wire [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_end
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        rx_frame_end = 1'b0;
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_data <= ~q[i];
        end
        @(posedge clk);
        rx_frame_end <= 1'b1;
        @(posedge clk);
        rx_frame_end <= 1'b0;
    endtask
    // Stalls reach the reply path only
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        ph <= ph + 2'h1;
        tx_ready <= !slow || ph[1];
    end
endmodule // mbs_master

/* dv/mbs_slave_bench.sv */
// Bench for the RTU slave: register bus, fieldbus streams, serial requests.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module mbs_slave_bench;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0, t = 1'b0;
    logic fb_in_valid = 1'b0, fb_in_last = 1'b0, fb_out_ready = 1'b0;
    logic [1:0] avs_address = 2'h0;
    logic [31:0] avs_writedata = 32'h0, seed = 32'hb634;
    logic [3:0] slave_id_high_switch = 4'h0, slave_id_low_switch = 4'h0;
    logic [7:0] fb_in_data = 8'h00, id, bin[0:63], bout[0:63], nfb = 8'h00;
    logic [8:0] fbq[$];
    wire [31:0] avs_readdata;
    wire [7:0] rx_data, tx_data, fb_out_data;
    wire avs_waitrequest, rx_valid, rx_frame_end, tx_valid, tx_ready, fb_out_valid, fb_out_last;
    int miscompares = 0, compares = 0;
    mbs_slave i_mbs_slave (.*);
    mbs_master i_mbs_master (.*);
    always #10 clk = ~clk;
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    always @(posedge clk) begin
        if (fb_out_valid && fb_out_ready)
            fbq.push_back({fb_out_last, fb_out_data});
        fb_out_ready <= xs() > 8'h50;
    end
    task automatic conclude();
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        tmo(n, 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic fbs(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            fb_in_valid <= 1'b1;
            fb_in_data <= q[i];
            fb_in_last <= i == q.size() - 1;
        end
        @(posedge clk);
        fb_in_valid <= 1'b0;
        fb_in_last <= 1'b0;
        fb_in_data <= ~fb_in_data;
    endtask
    task automatic xact(input logic [7:0] q[$], input logic [7:0] e[$]);
        logic [15:0] c;
        int n;
        i_mbs_master.send(q, 1'b0);
        c = i_mbs_master.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        for (n = 0; n < 2000 && i_mbs_master.got.size() < e.size(); n++)
            @(posedge clk);
        tmo(n, 2000);
        foreach (e[i])
            chk(i_mbs_master.got[i], e[i]);
        i_mbs_master.got.delete();
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n);
        logic [7:0] q[$];
        logic [7:0] e[$];
        int k, b;
        k = fc < 8'h03 ? (n + 7) / 8 : 2 * n;
        b = fc < 8'h03 ? a / 8 : 2 * a;
        q = {id, fc, a[15:8], a[7:0], n[15:8], n[7:0]};
        e = {id, fc, k[7:0]};
        for (int i = 0; i < k; i++)
            e.push_back(fc == 8'h03 ? bout[b + i] : bin[b + i]);
        xact(q, e);
    endtask
    task automatic wr(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n,
                      input logic [7:0] d[$]);
        logic [7:0] q[$];
        logic [7:0] e[$];
        int k, b;
        b = fc == 8'h0f ? a / 8 : 2 * a;
        q = {id, fc, a[15:8], a[7:0], n[15:8], n[7:0]};
        e = q;
        if (fc == 8'h06)
            d = {n[15:8], n[7:0]};
        if (fc == 8'h05) begin
            bin[a / 8][a % 8] = n[15];
            bout[a / 8][a % 8] = n[15];
        end else begin
            for (k = 0; k < d.size(); k++) begin
                bin[b + k] = d[k];
                bout[b + k] = d[k];
            end
        end
        k = d.size();
        if (fc > 8'h06)
            q = {q, k[7:0], d};
        xact(q, e);
        for (k = 0; k < 2000 && fbq.size() < 17 + t; k++)
            @(posedge clk);
        tmo(k, 2000);
        chk(fbq[t], 9'h010);
        for (k = 0; k < 16; k++)
            chk(fbq[t + 1 + k], {k == 15, bout[k]});
        // Trigger byte counts earlier output frames
        if (t)
            chk(fbq[0], {1'b0, nfb});
        nfb = nfb + 8'h01;
        fbq.delete();
    endtask
    initial begin
        logic [31:0] r;
        logic [7:0] d[$];
        id = xs();
        slave_id_high_switch <= id[7:4];
        slave_id_low_switch <= id[3:0];
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        bus(1'b0, 2'h0, 32'h0, r);
        chk(r, 32'h2);
        bus(1'b0, 2'h1, 32'h0, r);
        chk(r, 32'h10);
        bus(1'b1, 2'h3, 32'hffffffff, r);
        bus(1'b0, 2'h3, 32'h0, r);
        chk(r, 32'h0);
        bus(1'b1, 2'h2, 32'h0, r);
        bus(1'b0, 2'h2, 32'h0, r);
        chk(r[7:0], id);
        d = {8'h10};
        repeat (17) d.push_back(xs());
        for (int i = 0; i < 16; i++)
            bin[i] = d[i + 1];
        fbs(d);
        d = {8'h08};
        repeat (13) d.push_back(xs());
        for (int i = 0; i < 8; i++)
            bin[i] = d[i + 1];
        fbs(d);
        repeat (4) @(posedge clk);
        rd(8'h01, 16'h0003, 16'd80);
        rd(8'h02, 16'h000c, 16'd9);
        chk(fbq.size(), 0);
        d.delete();
        repeat (16) d.push_back(xs());
        slow <= 1'b1;
        wr(8'h10, 16'h0000, 16'd8, d);
        wr(8'h06, 16'h0007, {xs(), xs()}, d);
        rd(8'h03, 16'h0007, 16'd1);
        wr(8'h05, 16'h0002, 16'hff00, d);
        rd(8'h01, 16'h0000, 16'd16);
        wr(8'h05, 16'h0002, 16'h0000, d);
        bus(1'b1, 2'h0, 32'h3, r);
        t = 1'b1;
        d = {xs()};
        wr(8'h0f, 16'h0008, 16'd8, d);
        d = {xs(), xs(), xs(), xs()};
        wr(8'h10, 16'h0005, 16'd2, d);
        rd(8'h04, 16'h0000, 16'd8);
        rd(8'h03, 16'h0000, 16'd8);
        // Inbound trigger byte skipped, then length, then two data bytes
        d = {8'h00, 8'h02, xs(), xs(), 8'h00};
        bin[0] = d[2];
        bin[1] = d[3];
        fbs(d);
        repeat (4) @(posedge clk);
        rd(8'h04, 16'h0000, 16'd1);
        d = {id ^ 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
        i_mbs_master.send(d, 1'b0);
        d[0] = id;
        i_mbs_master.send(d, 1'b1);
        // Unknown function code is not served
        d[1] = 8'h07;
        i_mbs_master.send(d, 1'b0);
        repeat (40) @(posedge clk);
        chk(i_mbs_master.got.size(), 0);
        chk(fbq.size(), 0);
        bus(1'b0, 2'h2, 32'h0, r);
        chk(r, {8'h00, 8'h01, 8'h0d, id});
        conclude();
    end
endmodule // mbs_slave_bench
